// [rtl/tsw_consts.svh]
// Constants for the time-slot interchange switch: fields, codes and timing
`ifndef TSW_CONSTS_SVH
`define TSW_CONSTS_SVH

// ****************************************
// Control register fields
// ****************************************
`define TSW_CR_RESET 8'h00
`define TSW_CR_SPLIT_BIT 7
`define TSW_CR_BCAST_BIT 6
`define TSW_CR_SEL_HI 4
`define TSW_CR_SEL_LO 3
`define TSW_SEL_DATA 2'h1
`define TSW_SEL_CML 2'h2
`define TSW_SEL_CMH 2'h3

// ****************************************
// Connection high fields, address split
// ****************************************
`define TSW_CMH_OE_BIT 0
`define TSW_CMH_MSG_BIT 2
`define TSW_ADDR_MEM_BIT 5

// ****************************************
// Serial timing
// ****************************************
`define TSW_FRAME_NS 125000
`define TSW_SCLK_KHZ 4096
`define TSW_EDGES_PER_FRAME ((`TSW_FRAME_NS * `TSW_SCLK_KHZ) / 1000000)

`endif

// [rtl/tsw_pkg.sv]
// Types shared by the time-slot interchange switch
package tsw_pkg;
    typedef logic [7:0] tsw_byte_type;
    typedef logic [8:0] tsw_slot_type;
    typedef logic [6:0] tsw_idx_type;
    typedef enum logic {TSW_IDLE, TSW_DONE} tsw_host_state_type;
endpackage

// [rtl/tsw_link_timing.sv]
// Serial link sampling, frame alignment and half-bit slot counter
`timescale 1ns/1ns
`default_nettype none
`include "tsw_consts.svh"
module tsw_link_timing
    import tsw_pkg::*;
#(
    parameter int LINES = 4
) (
    input wire logic clk_sys,
    input wire logic rst_s_b,
    input wire logic serial_clock_4m,
    input wire logic frame_sync_n,
    input wire logic [LINES-1:0] serial_in_lines,
    output tsw_slot_type slot_r,
    output logic step_r,
    output logic [LINES-1:0] rx_bits
);
    localparam tsw_slot_type SLOT_LAST = 9'(`TSW_EDGES_PER_FRAME - 1);

    // Synchroniser stages
    logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic fs_s1_r, fs_s2_r;
    logic [LINES-1:0] rx_s1_r, rx_s2_r;
    // Frame pending flag and counter next values
    logic pend_r, pend_nxt;
    tsw_slot_type slot_nxt;
    logic fall;

    // ****************************************
    // Input synchronisers
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_s_b) begin
        if (!rst_s_b) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            fs_s1_r <= 1'b1;
            fs_s2_r <= 1'b1;
            rx_s1_r <= '0;
            rx_s2_r <= '0;
        end else begin
            sclk_s1_r <= serial_clock_4m;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            fs_s1_r <= frame_sync_n;
            fs_s2_r <= fs_s1_r;
            rx_s1_r <= serial_in_lines;
            rx_s2_r <= rx_s1_r;
        end
    end

    // Falling edge of the serial clock, seen after synchronising
    assign fall = sclk_s3_r & ~sclk_s2_r;
    assign rx_bits = rx_s2_r;

    // ****************************************
    // Slot counter next values
    // ****************************************
    always_comb begin
        pend_nxt = pend_r;
        slot_nxt = slot_r;
        if (fall) begin
            pend_nxt = ~fs_s2_r;
            // Frame pulse seen last edge restarts the count
            if (pend_r) begin
                slot_nxt = '0;
            end else if (slot_r == SLOT_LAST) begin
                slot_nxt = '0;
            end else begin
                slot_nxt = slot_r + 9'h001;
            end
        end
    end

    // Counter registers
    always_ff @(posedge clk_sys or negedge rst_s_b) begin
        if (!rst_s_b) begin
            pend_r <= 1'b0;
            slot_r <= '0;
            step_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            slot_r <= slot_nxt;
            step_r <= fall;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_s_b);

    frame_restart_a: assert property ((fall && pend_r) |=> (slot_r == 9'h000))
        else $error("slot counter not restarted by frame pulse");
    count_on_edge_a: assert property (!fall |=> $stable(slot_r))
        else $error("slot counter moved without a clock edge");

endmodule // tsw_link_timing
`default_nettype wire

// [rtl/tsw_switch.sv]
// Time-slot interchange switch top: processor port, memories, serial paths
//
// Notes on behaviour
// - Four serial lines in and out, 32 channels.
// - Any input channel routes to any output.
// - Processor reads received and writes sent channels.
// - Serial bit cell spans two clock falls.
// - Frame pulse low resets counter next fall.
// - Active-high strobe qualifies each access.
// - Direction high reads, low writes.
// - Chip select high ignores accesses.
// - Six address bits choose the location.
// - Drive data on reads, sample on writes.
// - Acknowledge pulled low when access completes.
// - Output drive enable high drives outputs.
// - Output drive enable low floats outputs.
// - Per-channel configuration may float channels.
// - Frames of 32 bytes, running continuously.
// - Low top address bit selects control register.
// - Message channels repeat the written byte.
// - Split mode reads data, writes connection-low.
`timescale 1ns/1ns
`default_nettype none
`include "tsw_consts.svh"
module tsw_switch
    import tsw_pkg::*;
#(
    parameter int LINES = 4
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic serial_clock_4m,
    input wire logic frame_sync_n,
    input wire logic [LINES-1:0] serial_in_lines,
    output logic [LINES-1:0] serial_out_lines,
    output logic [LINES-1:0] serial_out_oe,
    input wire logic output_drive_enable,
    input wire logic chip_select_n,
    input wire logic data_strobe,
    input wire logic read_write,
    input wire logic [5:0] host_addr,
    input wire logic [7:0] host_data_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe,
    input wire logic access_ack_n_i,
    output logic access_ack_n_o,
    output logic access_ack_n_oe
);
    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    logic rst_s1_r, rst_s_b;
    logic cs_s1_r, cs_s_r, stb_s1_r, stb_s_r, rw_s1_r, rw_s_r, drv_s1_r, drv_s_r;
    logic [5:0] addr_s1_r, addr_s_r;
    tsw_byte_type wd_s1_r, wd_s_r;

    // Reset leaves through two flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_s_b <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s_b <= rst_s1_r;
        end
    end

    // Processor pins and drive enable, two flops each
    always_ff @(posedge clk_sys or negedge rst_s_b) begin
        if (!rst_s_b) begin
            cs_s1_r <= 1'b1;
            cs_s_r <= 1'b1;
            stb_s1_r <= 1'b0;
            stb_s_r <= 1'b0;
            rw_s1_r <= 1'b1;
            rw_s_r <= 1'b1;
            drv_s1_r <= 1'b0;
            drv_s_r <= 1'b0;
            addr_s1_r <= 6'h00;
            addr_s_r <= 6'h00;
            wd_s1_r <= 8'h00;
            wd_s_r <= 8'h00;
        end else begin
            cs_s1_r <= chip_select_n;
            cs_s_r <= cs_s1_r;
            stb_s1_r <= data_strobe;
            stb_s_r <= stb_s1_r;
            rw_s1_r <= read_write;
            rw_s_r <= rw_s1_r;
            drv_s1_r <= output_drive_enable;
            drv_s_r <= drv_s1_r;
            addr_s1_r <= host_addr;
            addr_s_r <= addr_s1_r;
            wd_s1_r <= host_data_i;
            wd_s_r <= wd_s1_r;
        end
    end

    // ****************************************
    // Link timing
    // ****************************************
    tsw_slot_type slot_r;
    logic step_r;
    logic [LINES-1:0] rx_bits;

    tsw_link_timing #(.LINES(LINES)) u_timing (
        .clk_sys(clk_sys),
        .rst_s_b(rst_s_b),
        .serial_clock_4m(serial_clock_4m),
        .frame_sync_n(frame_sync_n),
        .serial_in_lines(serial_in_lines),
        .slot_r(slot_r),
        .step_r(step_r),
        .rx_bits(rx_bits)
    );

    // Memory index from line and channel
    function automatic tsw_idx_type mem_idx(input logic [1:0] line, input logic [4:0] ch);
        mem_idx = {line, ch};
    endfunction

    // Memories: received data, connection low and high
    tsw_byte_type dm [128];
    tsw_byte_type cml [128];
    tsw_byte_type cmh [128];

    // ****************************************
    // Processor port
    // ****************************************
    tsw_host_state_type st_r, st_nxt;
    tsw_byte_type ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
    logic rd_r, rd_nxt, req, cml_we, cmh_we;
    logic [1:0] sel;
    tsw_idx_type host_idx;

    assign req = ~cs_s_r & stb_s_r;
    assign sel = ctrl_r[`TSW_CR_SEL_HI:`TSW_CR_SEL_LO];
    assign host_idx = mem_idx(ctrl_r[1:0], addr_s_r[4:0]);

    // Access decode and next values
    always_comb begin
        st_nxt = st_r;
        ctrl_nxt = ctrl_r;
        rdata_nxt = rdata_r;
        rd_nxt = rd_r;
        cml_we = 1'b0;
        cmh_we = 1'b0;
        unique case (st_r)
            TSW_IDLE: begin
                if (req) begin
                    st_nxt = TSW_DONE;
                    rd_nxt = rw_s_r;
                    if (rw_s_r) begin
                        // Read mux
                        if (!addr_s_r[`TSW_ADDR_MEM_BIT]) begin
                            rdata_nxt = ctrl_r;
                        end else if (ctrl_r[`TSW_CR_SPLIT_BIT] || sel == `TSW_SEL_DATA) begin
                            rdata_nxt = dm[host_idx];
                        end else if (sel == `TSW_SEL_CMH) begin
                            rdata_nxt = cmh[host_idx];
                        end else begin
                            rdata_nxt = cml[host_idx];
                        end
                    end else if (!addr_s_r[`TSW_ADDR_MEM_BIT]) begin
                        ctrl_nxt = wd_s_r;
                    end else if (ctrl_r[`TSW_CR_SPLIT_BIT] || sel == `TSW_SEL_CML) begin
                        cml_we = 1'b1;
                    end else if (sel == `TSW_SEL_CMH) begin
                        cmh_we = 1'b1;
                    end
                end
            end
            TSW_DONE: begin
                // Hold the answer until strobe or select leaves
                if (!req) begin
                    st_nxt = TSW_IDLE;
                end
            end
        endcase
    end

    // Processor port registers
    always_ff @(posedge clk_sys or negedge rst_s_b) begin
        if (!rst_s_b) begin
            st_r <= TSW_IDLE;
            ctrl_r <= `TSW_CR_RESET;
            rdata_r <= 8'h00;
            rd_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            rd_r <= rd_nxt;
        end
    end

    // Connection memories, written by the processor only
    always_ff @(posedge clk_sys) begin
        if (cml_we) begin
            cml[host_idx] <= wd_s_r;
        end
        if (cmh_we) begin
            cmh[host_idx] <= wd_s_r;
        end
    end

    // Open-drain acknowledge and read data drive
    assign access_ack_n_o = 1'b0;
    assign access_ack_n_oe = (st_r == TSW_DONE);
    assign host_data_o = rdata_r;
    assign host_data_oe = (st_r == TSW_DONE) & rd_r;

    // ****************************************
    // Serial receive and transmit
    // ****************************************
    tsw_byte_type rx_sh_r [LINES], rx_sh_nxt [LINES];
    tsw_byte_type tx_sh_r [LINES], tx_sh_nxt [LINES];
    logic [LINES-1:0] ch_oe_r, ch_oe_nxt, dm_we;
    tsw_byte_type dm_wd [LINES];
    logic [4:0] ch;
    logic [2:0] bitn;
    logic bcast;

    assign ch = slot_r[8:4];
    assign bitn = slot_r[3:1];
    assign bcast = ctrl_r[`TSW_CR_BCAST_BIT];

    // Shift, load and store decisions per line
    always_comb begin
        for (int i = 0; i < LINES; i++) begin
            rx_sh_nxt[i] = rx_sh_r[i];
            tx_sh_nxt[i] = tx_sh_r[i];
            ch_oe_nxt[i] = ch_oe_r[i];
            dm_we[i] = 1'b0;
            dm_wd[i] = {rx_sh_r[i][6:0], rx_bits[i]};
            if (step_r && slot_r[0]) begin
                // Mid-cell: take the input bit, MSB first
                rx_sh_nxt[i] = {rx_sh_r[i][6:0], rx_bits[i]};
                dm_we[i] = (bitn == 3'h7);
            end else if (step_r && bitn == 3'h0) begin
                // Cell boundary opening a channel: load its byte
                if (bcast || cmh[mem_idx(2'(i), ch)][`TSW_CMH_MSG_BIT]) begin
                    tx_sh_nxt[i] = cml[mem_idx(2'(i), ch)];
                end else begin
                    tx_sh_nxt[i] = dm[cml[mem_idx(2'(i), ch)][6:0]];
                end
                ch_oe_nxt[i] = bcast | cmh[mem_idx(2'(i), ch)][`TSW_CMH_OE_BIT];
            end else if (step_r) begin
                tx_sh_nxt[i] = {tx_sh_r[i][6:0], 1'b0};
            end
        end
    end

    // Serial registers
    always_ff @(posedge clk_sys or negedge rst_s_b) begin
        if (!rst_s_b) begin
            for (int i = 0; i < LINES; i++) begin
                rx_sh_r[i] <= 8'h00;
                tx_sh_r[i] <= 8'hff;
            end
            ch_oe_r <= '0;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                rx_sh_r[i] <= rx_sh_nxt[i];
                tx_sh_r[i] <= tx_sh_nxt[i];
            end
            ch_oe_r <= ch_oe_nxt;
        end
    end

    // Data memory, written by the receive path only
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < LINES; i++) begin
            if (dm_we[i]) begin
                dm[mem_idx(2'(i), ch)] <= dm_wd[i];
            end
        end
    end

    // Outputs: MSB of each shifter, gated by the drive enable pin
    generate
        for (genvar g = 0; g < LINES; g++) begin : g_out
            assign serial_out_lines[g] = tx_sh_r[g][7];
            assign serial_out_oe[g] = drv_s_r & ch_oe_r[g];
        end
    endgenerate

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_s_b);

    sequence host_req_s;
        (st_r == TSW_IDLE) && !cs_s_r && stb_s_r;
    endsequence

    ack_set_a: assert property (host_req_s |=> access_ack_n_oe)
        else $error("access not acknowledged");
    ack_release_a: assert property ((access_ack_n_oe && !req) |=> !access_ack_n_oe[*2])
        else $error("acknowledge held after strobe left");
    select_ignore_a: assert property ((!access_ack_n_oe && cs_s_r) |=> !access_ack_n_oe)
        else $error("access taken while deselected");
    data_drive_a: assert property (host_data_oe |-> (access_ack_n_oe && rd_r))
        else $error("data driven outside a read");
    ctrl_write_a: assert property ((host_req_s and !rw_s_r && !addr_s_r[5])
        |=> (ctrl_r == $past(wd_s_r)))
        else $error("control register write lost");
    split_read_a: assert property ((host_req_s and rw_s_r && addr_s_r[5] && ctrl_r[7])
        |=> (host_data_o == $past(dm[host_idx])))
        else $error("split read not from data memory");
    drive_off_a: assert property (!drv_s_r |-> (serial_out_oe == '0))
        else $error("outputs driven while drive disabled");
    bcast_drive_a: assert property ((drv_s_r && bcast && step_r && slot_r[3:0] == 4'h0)
        |=> (serial_out_oe == '1))
        else $error("broadcast channel not driven");

endmodule // tsw_switch
`default_nettype wire

// [tb/tsw_tdm_partner.sv]
// Far-side serial model: link clock, frame pulse, input streams, output capture
`timescale 1ns/1ns
`default_nettype none
module tsw_tdm_partner (
    output logic serial_clock_4m,
    output logic frame_sync_n,
    output logic [3:0] serial_in_lines,
    input wire logic [3:0] serial_out_lines,
    input wire logic [3:0] serial_out_oe
);
    // ****************************************
    // Captured output bytes and drive flags
    // ****************************************
    logic [7:0] out_byte [4][32];
    logic out_oe [4][32];
    int k;
    int b;
    // Byte being sent on the current line
    logic [7:0] pat;
    // Free-running clock, unrelated phase; falls indexed 0..511 per frame
    initial begin
        serial_clock_4m = 1'b1;
        frame_sync_n = 1'b1;
        serial_in_lines = 4'hf;
        k = 0;
        #13;
        forever begin
            #200 serial_clock_4m = 1'b0;
            b = 7 - ((k >> 1) & 7);
            for (int l = 0; l < 4; l++) begin
                if (k % 2 == 0) begin
                    // Input bit launched at the cell boundary, MSB first
                    pat = {l[1:0], 1'b1, k[8:4]};
                    serial_in_lines[l] = pat[b];
                end else begin
                    // Mid-cell sample of the device output
                    out_byte[l][k >> 4][b] = serial_out_lines[l];
                    out_oe[l][k >> 4] = (b == 7) ? serial_out_oe[l]
                        : (out_oe[l][k >> 4] & serial_out_oe[l]);
                end
            end
            k = (k + 1) % 512;
            #200 serial_clock_4m = 1'b1;
            // Frame pulse low around the last fall of each frame
            frame_sync_n = (k == 511) ? 1'b0 : 1'b1;
        end
    end
endmodule // tsw_tdm_partner
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the time-slot interchange switch
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // ****************************************
    // Stimulus and wires
    // ****************************************
    logic clk_sys;
    logic rst_b;
    logic output_drive_enable;
    logic chip_select_n;
    logic data_strobe;
    logic read_write;
    logic [5:0] host_addr;
    logic [7:0] tb_data;
    logic tb_data_en;
    logic [7:0] float_pat = 8'h00;
    wire logic [7:0] host_data_i;
    wire logic [7:0] host_data_o;
    wire logic host_data_oe;
    wire logic access_ack_n_i;
    wire logic access_ack_n_o;
    wire logic access_ack_n_oe;
    wire logic serial_clock_4m;
    wire logic frame_sync_n;
    wire logic [3:0] serial_in_lines;
    wire logic [3:0] serial_out_lines;
    wire logic [3:0] serial_out_oe;
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] q;
    // Released bus shows a changing pattern; acknowledge has a pull-up
    assign host_data_i = host_data_oe ? host_data_o : (tb_data_en ? tb_data : float_pat);
    assign access_ack_n_i = access_ack_n_oe ? access_ack_n_o : 1'b1;
    tsw_switch #(.LINES(4)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .serial_clock_4m(serial_clock_4m), .frame_sync_n(frame_sync_n),
        .serial_in_lines(serial_in_lines), .serial_out_lines(serial_out_lines),
        .serial_out_oe(serial_out_oe), .output_drive_enable(output_drive_enable),
        .chip_select_n(chip_select_n), .data_strobe(data_strobe),
        .read_write(read_write), .host_addr(host_addr), .host_data_i(host_data_i),
        .host_data_o(host_data_o), .host_data_oe(host_data_oe),
        .access_ack_n_i(access_ack_n_i), .access_ack_n_o(access_ack_n_o),
        .access_ack_n_oe(access_ack_n_oe));
    tsw_tdm_partner p (.serial_clock_4m(serial_clock_4m), .frame_sync_n(frame_sync_n),
        .serial_in_lines(serial_in_lines), .serial_out_lines(serial_out_lines),
        .serial_out_oe(serial_out_oe));
    // Clock 20 MHz
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) float_pat <= float_pat + 8'h3b;
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One strobed access, held until acknowledged, released afterwards
    task automatic access(input logic rw, input logic [5:0] a, input logic [7:0] d,
                          output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        #5;
        chip_select_n = 1'b0;
        read_write = rw;
        host_addr = a;
        tb_data = d;
        tb_data_en = ~rw;
        data_strobe = 1'b1;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (access_ack_n_i !== 1'b0 && n < 20);
        chk("ack", 8'h00, {7'h0, access_ack_n_i});
        chk("data drive", {7'h0, rw}, {7'h0, host_data_oe});
        rd = host_data_o;
        #4;
        data_strobe = 1'b0;
        chip_select_n = 1'b1;
        tb_data_en = 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (access_ack_n_oe !== 1'b0 && n < 10);
        chk("ack release", 8'h00, {7'h0, access_ack_n_oe});
        chk("data release", 8'h00, {7'h0, host_data_oe});
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        access(1'b0, a, d, q);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_ctrl();
        wr(6'h1f, 8'h0b);
        access(1'b1, 6'h00, 8'h00, q);
        chk("control readback", 8'h0b, q);
    endtask
    task automatic t_deselect();
        int seen;
        seen = 0;
        @(posedge clk_sys);
        #5;
        read_write = 1'b0;
        host_addr = 6'h00;
        tb_data = 8'hff;
        tb_data_en = 1'b1;
        data_strobe = 1'b1;
        repeat (12) begin
            @(posedge clk_sys);
            #1;
            if (access_ack_n_oe !== 1'b0) seen++;
        end
        #4;
        data_strobe = 1'b0;
        tb_data_en = 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("deselected ack", 8'h00, seen[7:0]);
        access(1'b1, 6'h00, 8'h00, q);
        chk("control kept", 8'h0b, q);
    endtask
    task automatic t_data_read();
        for (int l = 0; l < 4; l++) begin
            wr(6'h00, 8'h08 | l[7:0]);
            access(1'b1, 6'h20, 8'h00, q);
            chk("data ch0", {l[1:0], 6'h20}, q);
            access(1'b1, 6'h3f, 8'h00, q);
            chk("data ch31", {l[1:0], 6'h3f}, q);
        end
    endtask
    task automatic t_message_split();
        wr(6'h00, 8'h19);
        wr(6'h25, 8'h05);
        wr(6'h00, 8'h81);
        wr(6'h25, 8'ha5);
        access(1'b1, 6'h25, 8'h00, q);
        chk("split read", 8'h65, q);
        #409600;
        chk("message byte", 8'ha5, p.out_byte[1][5]);
        chk("message drive", 8'h01, {7'h0, p.out_oe[1][5]});
    endtask
    task automatic t_switch();
        wr(6'h00, 8'h1a);
        wr(6'h27, 8'h01);
        wr(6'h28, 8'h00);
        wr(6'h00, 8'h12);
        wr(6'h27, 8'h7e);
        wr(6'h00, 8'h18);
        wr(6'h3f, 8'h01);
        wr(6'h00, 8'h10);
        wr(6'h3f, 8'h00);
        wr(6'h00, 8'h12);
        access(1'b1, 6'h27, 8'h00, q);
        chk("conn low read", 8'h7e, q);
        wr(6'h00, 8'h1a);
        access(1'b1, 6'h27, 8'h00, q);
        chk("conn high read", 8'h01, q);
        #409600;
        chk("switched 3.30", 8'hfe, p.out_byte[2][7]);
        chk("switched 0.0", 8'h20, p.out_byte[0][31]);
        chk("channel float", 8'h00, {7'h0, p.out_oe[2][8]});
    endtask
    // Broadcast: every channel sends its connection low byte and drives
    task automatic t_bcast();
        wr(6'h00, 8'h40);
        #409600;
        chk("broadcast byte", 8'h7e, p.out_byte[2][7]);
        chk("broadcast drive", 8'h01, {7'h0, p.out_oe[2][8]});
        wr(6'h00, 8'h00);
    endtask
    task automatic t_ode();
        int bad;
        bad = 0;
        @(posedge clk_sys);
        #5;
        output_drive_enable = 1'b0;
        repeat (10) @(posedge clk_sys);
        repeat (4000) begin
            @(posedge clk_sys);
            #1;
            if (serial_out_oe !== 4'h0) bad++;
        end
        chk("all float", 8'h00, {7'h0, bad != 0});
        #4 output_drive_enable = 1'b1;
        #409600;
        chk("drive back", 8'h01, {7'h0, p.out_oe[1][5]});
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        rst_b = 1'b0;
        output_drive_enable = 1'b1;
        chip_select_n = 1'b1;
        data_strobe = 1'b0;
        read_write = 1'b1;
        host_addr = 6'h00;
        tb_data = 8'h00;
        tb_data_en = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("reset drive", 8'h00, {5'h0, host_data_oe, access_ack_n_oe, |serial_out_oe});
        #4 rst_b = 1'b1;
        #409600;
        t_ctrl();
        t_deselect();
        t_data_read();
        t_message_split();
        t_switch();
        t_bcast();
        t_ode();
        close_out();
    end
    initial begin
        #3000000;
        n_fail++;
        close_out();
    end
endmodule // testbench
`default_nettype wire
